//--- common/stb_pkg.sv
// Constants shared by the stop-mode standby controller.
// Assumes a 32-bit APB register slave and a single mclk domain.
package stb_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_SETTLE = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;

    // Control register fields
    localparam int CTRL_W = 7;
    localparam int CTRL_LOWOSC_SEL = 0;
    localparam int CTRL_SUB_XT = 1;
    localparam int CTRL_SUB_EXT = 2;
    localparam int CTRL_FIH = 4;
    localparam int CTRL_FX = 5;
    localparam int CTRL_FEX = 6;
    localparam logic [6:0] CTRL_RST = 7'h10;

    // Settle select register
    localparam int SETTLE_W = 3;
    localparam logic [2:0] SETTLE_RST = 3'h7;
    localparam int SETTLE_BASE_CYC = 256;

    // Status register fields
    localparam int ST_IN_STOP = 0;
    localparam int ST_SETTLING = 1;
    localparam int ST_SLOWOSC = 2;
    localparam int ST_REFUSED = 3;

    typedef enum logic [1:0] {
        st_run,
        st_stop,
        st_settle
    } stb_state_t;

endpackage

//--- core/stb_settle_timer.sv
// Oscillation settle wait counter.
// Assumes start is a one-cycle pulse in the mclk domain.
`timescale 1ns/1ps
module stb_settle_timer #(
    parameter int BASE = 256,
    parameter int SEL_W = 3
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic start,
    input wire logic [SEL_W-1:0] sel,
    output logic busy,
    output logic done
);
    localparam int CW = $clog2(BASE) + (1 << SEL_W) + 1;

    if (BASE < 1 || SEL_W < 1 || SEL_W > 4) begin : g_chk
        $error("stb_settle_timer: unsupported BASE or SEL_W");
    end

    logic [CW-1:0] cnt_ff;
    logic busy_ff;

    // Wait length is BASE shifted left by sel
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            cnt_ff <= '0;
            busy_ff <= 1'b0;
        end else if (start) begin
            cnt_ff <= (CW'(BASE) << sel) - CW'(1);
            busy_ff <= 1'b1;
        end else if (busy_ff) begin
            cnt_ff <= cnt_ff - CW'(1);
            busy_ff <= (cnt_ff != '0);
        end
    end

    assign busy = busy_ff;
    assign done = busy_ff && (cnt_ff == '0);
endmodule

//--- core/stb_port_hold.sv
// Port output latch holder, frozen while standby is held.
// Assumes latch values come from logic on mclk.
`timescale 1ns/1ps
module stb_port_hold #(
    parameter int W = 8
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic hold,
    input wire logic [W-1:0] latch_in,
    output logic [W-1:0] port_out
);
    if (W < 1) begin : g_chk
        $error("stb_port_hold: W must be positive");
    end

    for (genvar i = 0; i < W; i++) begin : g_bit
        logic bit_ff;
        always_ff @(posedge mclk or posedge rst) begin
            if (rst) begin
                bit_ff <= 1'b0;
            end else if (!hold) begin
                bit_ff <= latch_in[i];
            end
        end
        assign port_out[i] = bit_ff;
    end
endmodule

//--- core/stb_stop_ctrl.sv
// Stop-mode standby controller: APB registers, entry FSM, clock gating.
// Assumes CPU and interrupt logic run on mclk and drive the stop request.
//
// What this block does
// - Deep standby is entered only by executing the stop instruction.
// - Entry allowed only when CPU ran from main system clock.
// - Pending unmasked interrupt at stop instruction clears standby at once.
// - After such clearing, resume only once the programmed settle wait ends.
// - Clocks keep running during that wait, like the halt state.
// - In standby the CPU clock supply is halted.
// - All three main clock sources stop on standby entry.
// - Subsystem crystal and external subclock keep their prior state.
// - Port output latches hold their prior values throughout standby.
// - Slow oscillator in standby follows option bits and clock select.
// - Clock select 1 keeps slow oscillator running in standby.
// - Clock select 0 and watchdog disabled stops slow oscillator.
// - Select 0, watchdog on, standby-run 1 keeps slow oscillator.
// - Select 0, watchdog on, standby-run 0 stops slow oscillator.
//
// Design decisions made here: the APB register port and the address map.
`timescale 1ns/1ps
module stb_stop_ctrl #(
    parameter int PORT_W = 8,
    parameter int SETTLE_BASE = stb_pkg::SETTLE_BASE_CYC
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic stop_exec,
    input wire logic cpu_on_main,
    input wire logic irq_pending,
    input wire logic wdog_standby_run,
    input wire logic wdog_enable_option,
    input wire logic [PORT_W-1:0] port_latch_in,
    output logic [PORT_W-1:0] port_out,
    output logic cpu_clk_en,
    output logic fast_internal_osc_en,
    output logic main_crystal_osc_en,
    output logic ext_main_clk_en,
    output logic sub_crystal_osc_en,
    output logic ext_sub_clk_en,
    output logic slow_internal_osc_en,
    output logic in_stop,
    output logic settling,
    output logic resume
);
    if (PORT_W < 1 || SETTLE_BASE < 1) begin : g_chk
        $error("stb_stop_ctrl: unsupported parameters");
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB decode

    logic [stb_pkg::CTRL_W-1:0] ctrl_ff;
    logic [stb_pkg::SETTLE_W-1:0] settle_sel_ff;
    logic refused_ff;
    logic [31:0] prdata_ff;
    stb_pkg::stb_state_t state_ff;
    stb_pkg::stb_state_t nxt_state;

    wire hit_ctrl = (paddr == stb_pkg::OFS_CTRL);
    wire hit_settle = (paddr == stb_pkg::OFS_SETTLE);
    wire hit_status = (paddr == stb_pkg::OFS_STATUS);
    wire hit_any = hit_ctrl || hit_settle || hit_status;
    wire setup_ph = psel && !penable;
    wire access_ph = psel && penable;
    wire wr_en = access_ph && pwrite && hit_any;
    wire wr_ctrl = wr_en && hit_ctrl;
    wire wr_settle = wr_en && hit_settle;
    wire wr_status = wr_en && hit_status;

    wire [31:0] status_word = {28'h0000000,
                               refused_ff,
                               slow_internal_osc_en,
                               settling,
                               in_stop};
    wire [31:0] rd_mux = hit_ctrl ? {25'h0, ctrl_ff} :
                         hit_settle ? {29'h0, settle_sel_ff} :
                         hit_status ? status_word : 32'h00000000;

    assign pready = 1'b1;
    assign pslverr = access_ph && !hit_any;
    assign prdata = prdata_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    // Read data sampled in the setup cycle
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            prdata_ff <= 32'h00000000;
        end else if (setup_ph) begin
            prdata_ff <= rd_mux;
        end
    end

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ctrl_ff <= stb_pkg::CTRL_RST;
            settle_sel_ff <= stb_pkg::SETTLE_RST;
        end else begin
            if (wr_ctrl) begin
                ctrl_ff <= pwdata[stb_pkg::CTRL_W-1:0];
            end
            if (wr_settle) begin
                settle_sel_ff <= pwdata[stb_pkg::SETTLE_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Entry and release state machine

    wire is_run = (state_ff == stb_pkg::st_run);
    wire is_stop = (state_ff == stb_pkg::st_stop);
    wire is_settle = (state_ff == stb_pkg::st_settle);
    // Only the stop instruction from main clock starts entry
    wire accept = is_run && stop_exec && cpu_on_main;
    wire refuse = is_run && stop_exec && !cpu_on_main;
    // Pending interrupt turns entry straight into the settle wait
    wire timer_start = (accept && irq_pending) || (is_stop && irq_pending);
    wire timer_busy;
    wire timer_done;

    // Refused request flag, set wins over write-one clear
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            refused_ff <= 1'b0;
        end else begin
            refused_ff <= refuse || (refused_ff && !(wr_status && pwdata[stb_pkg::ST_REFUSED]));
        end
    end

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            stb_pkg::st_run: begin
                if (accept) begin
                    nxt_state = irq_pending ? stb_pkg::st_settle : stb_pkg::st_stop;
                end
            end
            stb_pkg::st_stop: begin
                if (irq_pending) begin
                    nxt_state = stb_pkg::st_settle;
                end
            end
            stb_pkg::st_settle: begin
                if (timer_done) begin
                    nxt_state = stb_pkg::st_run;
                end
            end
            default: begin
                nxt_state = stb_pkg::st_run;
            end
        endcase
    end

    logic resume_ff;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            state_ff <= stb_pkg::st_run;
            resume_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            resume_ff <= is_settle && timer_done;
        end
    end

    stb_settle_timer #(
        .BASE(SETTLE_BASE),
        .SEL_W(stb_pkg::SETTLE_W)
    ) u_timer (
        .mclk(mclk),
        .rst(rst),
        .start(timer_start),
        .sel(settle_sel_ff),
        .busy(timer_busy),
        .done(timer_done)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Clock and port control

    wire lowosc_sel = ctrl_ff[stb_pkg::CTRL_LOWOSC_SEL];
    // Slow oscillator choice while stopped
    wire slow_keep = lowosc_sel || (wdog_enable_option && wdog_standby_run);

    assign in_stop = is_stop;
    assign settling = is_settle;
    assign resume = resume_ff;
    // CPU clock only in run; settle behaves as halt
    assign cpu_clk_en = is_run;
    // Main sources stay up during the settle wait
    assign fast_internal_osc_en = ctrl_ff[stb_pkg::CTRL_FIH] && !is_stop;
    assign main_crystal_osc_en = ctrl_ff[stb_pkg::CTRL_FX] && !is_stop;
    assign ext_main_clk_en = ctrl_ff[stb_pkg::CTRL_FEX] && !is_stop;
    // Subsystem sources follow software alone
    assign sub_crystal_osc_en = ctrl_ff[stb_pkg::CTRL_SUB_XT];
    assign ext_sub_clk_en = ctrl_ff[stb_pkg::CTRL_SUB_EXT];
    assign slow_internal_osc_en = is_stop ? slow_keep : 1'b1;

    stb_port_hold #(
        .W(PORT_W)
    ) u_ports (
        .mclk(mclk),
        .rst(rst),
        .hold(is_stop),
        .latch_in(port_latch_in),
        .port_out(port_out)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    localparam int HCW = $clog2(SETTLE_BASE) + (1 << stb_pkg::SETTLE_W) + 1;
    logic [HCW-1:0] settle_cyc_ff;
    logic [stb_pkg::SETTLE_W-1:0] sel_lat_ff;

    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            settle_cyc_ff <= '0;
            sel_lat_ff <= '0;
        end else begin
            settle_cyc_ff <= is_settle ? settle_cyc_ff + HCW'(1) : '0;
            if (timer_start) begin
                sel_lat_ff <= settle_sel_ff;
            end
        end
    end

    property p_entry_by_instr;
        @(posedge mclk) disable iff (rst)
        $rose(in_stop) |-> $past(stop_exec) && $past(cpu_on_main);
    endproperty
    a_entry_by_instr: assert property (p_entry_by_instr) else $error("stop entered without instruction");

    property p_no_sub_entry;
        @(posedge mclk) disable iff (rst)
        (is_run && stop_exec && !cpu_on_main) |=> is_run && refused_ff;
    endproperty
    a_no_sub_entry: assert property (p_no_sub_entry) else $error("stop taken off main clock");

    property p_irq_clears;
        @(posedge mclk) disable iff (rst)
        (is_run && stop_exec && cpu_on_main && irq_pending) |=> settling && !in_stop;
    endproperty
    a_irq_clears: assert property (p_irq_clears) else $error("pending interrupt did not clear stop");

    property p_settle_len;
        @(posedge mclk) disable iff (rst)
        $fell(settling) |-> settle_cyc_ff == (HCW'(SETTLE_BASE) << sel_lat_ff);
    endproperty
    a_settle_len: assert property (p_settle_len) else $error("settle wait length wrong");

    property p_settle_busy;
        @(posedge mclk) disable iff (rst)
        settling |-> timer_busy;
    endproperty
    a_settle_busy: assert property (p_settle_busy) else $error("settle state without running timer");

    property p_settle_clocks;
        @(posedge mclk) disable iff (rst)
        settling |-> fast_internal_osc_en == ctrl_ff[stb_pkg::CTRL_FIH] && !cpu_clk_en;
    endproperty
    a_settle_clocks: assert property (p_settle_clocks) else $error("clock stopped in settle wait");

    property p_cpu_gated;
        @(posedge mclk) disable iff (rst)
        $rose(in_stop) |-> !cpu_clk_en && $past(cpu_clk_en);
    endproperty
    a_cpu_gated: assert property (p_cpu_gated) else $error("cpu clock running in stop");

    property p_main_stopped;
        @(posedge mclk) disable iff (rst)
        in_stop |-> !fast_internal_osc_en && !main_crystal_osc_en && !ext_main_clk_en;
    endproperty
    a_main_stopped: assert property (p_main_stopped) else $error("main source running in stop");

    property p_sub_kept;
        @(posedge mclk) disable iff (rst)
        $rose(in_stop) |-> $stable(sub_crystal_osc_en) && $stable(ext_sub_clk_en);
    endproperty
    a_sub_kept: assert property (p_sub_kept) else $error("subclock changed on stop entry");

    property p_port_hold;
        @(posedge mclk) disable iff (rst)
        (in_stop && $past(in_stop)) |-> $stable(port_out);
    endproperty
    a_port_hold: assert property (p_port_hold) else $error("port latch changed in stop");

    property p_lowosc_sel;
        @(posedge mclk) disable iff (rst)
        (in_stop && lowosc_sel) |-> slow_internal_osc_en;
    endproperty
    a_lowosc_sel: assert property (p_lowosc_sel) else $error("slow osc stopped with select set");

    property p_wdog_off;
        @(posedge mclk) disable iff (rst)
        (in_stop && !lowosc_sel && !wdog_enable_option) |-> !slow_internal_osc_en;
    endproperty
    a_wdog_off: assert property (p_wdog_off) else $error("slow osc running, watchdog off");

    property p_wdog_run;
        @(posedge mclk) disable iff (rst)
        (in_stop && !lowosc_sel && wdog_enable_option && wdog_standby_run) |-> slow_internal_osc_en;
    endproperty
    a_wdog_run: assert property (p_wdog_run) else $error("slow osc stopped, standby-run set");

    property p_wdog_norun;
        @(posedge mclk) disable iff (rst)
        (in_stop && !lowosc_sel && wdog_enable_option && !wdog_standby_run) |-> !slow_internal_osc_en;
    endproperty
    a_wdog_norun: assert property (p_wdog_norun) else $error("slow osc running, standby-run clear");

endmodule

//--- tb/stb_cpu_model.sv
// CPU and interrupt request model facing the standby controller.
// Assumes the bench drives the req_* commands on mclk rising edges.
`timescale 1ns/1ps
module stb_cpu_model (
    input wire logic mclk,
    input wire logic rst,
    input wire logic req_stop,
    input wire logic req_sub,
    input wire logic req_irq,
    output logic stop_exec,
    output logic cpu_on_main,
    output logic irq_pending
);
    ////////////////////////////////////////////////////////////
    // Serial and converter wake setup taken as done before any stop
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            stop_exec <= 1'h0;
            cpu_on_main <= 1'h1;
            irq_pending <= 1'h0;
        end else begin
            stop_exec <= req_stop & ~stop_exec;
            cpu_on_main <= ~req_sub;
            irq_pending <= req_irq;
        end
    end
endmodule

//--- tb/stb_stop_ctrl_tb.sv
// Self-checking bench for the stop-mode standby controller.
// Assumes APB with pready from the design and a CPU model on the stop side.
`timescale 1ns/1ps
module stb_stop_ctrl_tb;
    localparam int BASE = 2;
    logic mclk = 1'h0;
    logic rst = 1'h1;
    logic psel = 1'h0;
    logic penable = 1'h0;
    logic pwrite = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err;
    logic req_stop = 1'h0;
    logic req_sub = 1'h0;
    logic req_irq = 1'h0;
    logic wdog_standby_run = 1'h0;
    logic wdog_enable_option = 1'h0;
    logic [7:0] port_latch_in = 8'h00;
    logic [7:0] port_out;
    logic stop_exec, cpu_on_main, irq_pending, cpu_clk_en, in_stop, settling, resume;
    logic fast_internal_osc_en, main_crystal_osc_en, ext_main_clk_en;
    logic sub_crystal_osc_en, ext_sub_clk_en, slow_internal_osc_en;
    logic [2:0] s;
    logic [6:0] c;
    int miscompares = 0;
    int cmp_count = 0;
    int n;

    always #20 mclk = ~mclk;

    stb_cpu_model stb_cpu_model_inst (.mclk, .rst, .req_stop, .req_sub, .req_irq,
        .stop_exec, .cpu_on_main, .irq_pending);

    stb_stop_ctrl #(.PORT_W(8), .SETTLE_BASE(BASE)) stb_stop_ctrl_inst (.mclk, .rst, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .stop_exec, .cpu_on_main, .irq_pending,
        .wdog_standby_run, .wdog_enable_option, .port_latch_in, .port_out, .cpu_clk_en,
        .fast_internal_osc_en, .main_crystal_osc_en, .ext_main_clk_en, .sub_crystal_osc_en,
        .ext_sub_clk_en, .slow_internal_osc_en, .in_stop, .settling, .resume);

    ////////////////////////////////////////////////////////////
    task report_and_stop;
        if (miscompares == 0 && cmp_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'h1;
        do begin
            @(posedge mclk);
        end while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask

    task rdchk(input logic [7:0] a, input logic [31:0] e, input string nm);
        apb(a, 1'h0, 32'h0);
        chk(nm, e, rd);
    endtask

    // Stop instruction pulse; returns one negedge after the design takes it
    task stop_go;
        @(posedge mclk);
        req_stop <= 1'h1;
        @(posedge mclk);
        req_stop <= 1'h0;
        repeat (2) @(negedge mclk);
    endtask

    task settle_chk(input int e);
        n = 0;
        while (settling !== 1'h1 && n < 20) begin
            @(negedge mclk);
            n++;
        end
        n = 0;
        while (settling === 1'h1 && n < 5000) begin
            n++;
            @(negedge mclk);
        end
        chk("settle_cycles", e, n);
        chk("resume", 32'h1, resume);
        chk("cpu_clk_en", 32'h1, cpu_clk_en);
    endtask

    ////////////////////////////////////////////////////////////
    initial begin
        repeat (5000) @(posedge mclk);
        miscompares++;
        report_and_stop;
    end

    initial begin
        repeat (3) @(posedge mclk);
        rst <= 1'h0;
        @(negedge mclk);
        chk("cpu_clk_en", 32'h1, cpu_clk_en);
        chk("in_stop", 32'h0, in_stop);
        rdchk(stb_pkg::OFS_CTRL, 32'h10, "ctrl_rst");
        rdchk(stb_pkg::OFS_SETTLE, 32'h7, "settle_rst");
        rdchk(stb_pkg::OFS_STATUS, 32'h4, "status_rst");
        rdchk(8'h0C, 32'h0, "unmapped");
        chk("pslverr", 32'h1, err);
        // Sel, enable and standby-run combinations, sub clocks and settle codes varied
        for (int i = 0; i < 8; i++) begin
            s = 3'(i % 4);
            c = 7'h70 | {4'h0, i[0], i[0], i[2]};
            apb(stb_pkg::OFS_SETTLE, 1'h1, {29'h0, s});
            apb(stb_pkg::OFS_CTRL, 1'h1, {25'h0, c});
            rdchk(stb_pkg::OFS_CTRL, {25'h0, c}, "ctrl_rw");
            wdog_enable_option <= i[1];
            wdog_standby_run <= i[0];
            port_latch_in <= 8'hA5 ^ 8'(i);
            stop_go;
            @(posedge mclk);
            port_latch_in <= 8'h5A;
            @(negedge mclk);
            chk("in_stop", 32'h1, in_stop);
            chk("cpu_clk_en", 32'h0, cpu_clk_en);
            chk("main_osc", 32'h0, {fast_internal_osc_en, main_crystal_osc_en, ext_main_clk_en});
            chk("sub_osc", {i[0], i[0]}, {ext_sub_clk_en, sub_crystal_osc_en});
            chk("slow_osc", i[2] | (i[1] & i[0]), slow_internal_osc_en);
            chk("port_hold", 8'hA5 ^ 8'(i), port_out);
            rdchk(stb_pkg::OFS_STATUS, {29'h0, i[2] | (i[1] & i[0]), 2'h1}, "status_stop");
            @(posedge mclk);
            req_irq <= 1'h1;
            settle_chk(BASE << s);
            @(posedge mclk);
            req_irq <= 1'h0;
        end
        // Stop with an interrupt already pending
        @(posedge mclk);
        req_irq <= 1'h1;
        stop_go;
        chk("settling", 32'h1, settling);
        chk("in_stop", 32'h0, in_stop);
        chk("fast_osc", 32'h1, fast_internal_osc_en);
        settle_chk(BASE << s);
        @(posedge mclk);
        req_irq <= 1'h0;
        // Stop while on the subsystem clock
        @(posedge mclk);
        req_sub <= 1'h1;
        stop_go;
        chk("in_stop", 32'h0, in_stop);
        rdchk(stb_pkg::OFS_STATUS, 32'hC, "status_refused");
        apb(stb_pkg::OFS_STATUS, 1'h1, 32'h8);
        rdchk(stb_pkg::OFS_STATUS, 32'h4, "status_clear");
        @(posedge mclk);
        req_sub <= 1'h0;
        report_and_stop;
    end
endmodule
